//--- core/als_cfg.svh
// Register map, field positions, reset values and autozero codes of the light-sensor control block.
// Assumes an I2C byte engine outside that turns bus traffic into register strobes on clk_i.
//
// How it works
// - With clear-on-read set, reading the status register clears every flag.
// - Sleep-after-interrupt is looked at when each light conversion cycle ends.
// - Enabled threshold interrupt pending plus sleep-after-interrupt stops the oscillator.
// - Asleep the block looks powered down, but power-on still reads as one.
// - Only clearing the pending flags wakes the oscillator again.
// - Autozero runs before every nth cycle; interval field bits 6:0 reset to ones.
// - Interval zero never autozeros; all ones autozeros once, before the first cycle.
// - Enable bit 7 gates saturation onto the interrupt; it resets to zero.
// - Threshold flag and its enable bit 4 both set drive the interrupt.
// - Writing one to a status bit clears that flag.
// - Threshold crossings set status bit 4.
// - Analog saturation sets status bit 7.
`ifndef ALS_CFG_SVH
`define ALS_CFG_SVH

`define ADDR_STATUS       8'h93
`define ADDR_IRQ_MODE     8'hab
`define ADDR_AZ_SCHED     8'hd6
`define ADDR_IRQ_EN       8'hdd

`define RST_IRQ_MODE      8'h4c
`define RST_AZ_SCHED      8'h7f
`define RST_IRQ_EN        8'h00
`define RD_IDLE           8'h00

`define BIT_CLEAR_ON_READ 7
`define BIT_SLEEP_IRQ     4
`define BIT_SAT_EN        7
`define BIT_ALS_EN        4
`define BIT_SAT_FLAG      7
`define BIT_ALS_FLAG      4

`define AZ_MSB            6
`define AZ_NEVER          7'h00
`define AZ_ONCE           7'h7f
`define AZ_CNT_ZERO       7'h00
`define AZ_CNT_ONE        7'h01

`endif

//--- core/als_pkg.sv
// Types shared by the light-sensor control block.
// Assumes the constants header is included by each design file.
package als_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [6:0] az_count_t;
  typedef enum logic {OSC_RUN, OSC_SLEEP} osc_state_t;
endpackage

//--- core/az_if.sv
// Carries conversion-start and autozero traffic between the control block and its scheduler.
// Assumes both ends run on clk_i.
interface az_if;
  logic               cycle_start;
  logic               restart;
  als_pkg::az_count_t interval;
  logic               az_req;
  modport ctrl  (output cycle_start, output restart, output interval, input az_req);
  modport sched (input cycle_start, input restart, input interval, output az_req);
endinterface

//--- core/az_sched.sv
// Autozero scheduler: decides before each conversion cycle whether autozero runs first.
// Assumes cycle_start and restart are one-cycle pulses on clk_i.
`include "als_cfg.svh"

module az_sched
  import als_pkg::*;
(
  input  wire logic clk_i,   // 250 MHz clock
  input  wire logic rst_n_i, // Synchronous reset, active low
  az_if.sched       az       // Schedule link to the control block
);
  az_count_t cnt_reg;
  logic      first_reg;
  logic      az_req_reg;
  logic      started_reg;

  // Counter is clamped with >= so a smaller interval written mid-stream cannot strand it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || az.restart) begin
      cnt_reg <= `AZ_CNT_ZERO;
    end else if (az.cycle_start) begin
      if (cnt_reg + `AZ_CNT_ONE >= az.interval) begin
        cnt_reg <= `AZ_CNT_ZERO;
      end else begin
        cnt_reg <= cnt_reg + `AZ_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || az.restart) begin
      first_reg <= 1'b1;
    end else if (az.cycle_start) begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      az_req_reg <= 1'b0;
    end else if (az.interval == `AZ_ONCE) begin
      az_req_reg <= az.cycle_start && first_reg;
    end else begin
      az_req_reg <= az.cycle_start && az.interval != `AZ_NEVER && cnt_reg == `AZ_CNT_ZERO;
    end
  end

  assign az.az_req = az_req_reg;

  // Helper for the once-mode check: an accepted start has been seen since the last restart
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || az.restart) begin
      started_reg <= 1'b0;
    end else if (az.cycle_start) begin
      started_reg <= 1'b1;
    end
  end

  a_az_never_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(az.interval) == `AZ_NEVER |-> !az_req_reg)
    else $error("autozero requested while disabled");

  a_az_once_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    started_reg && az.cycle_start && az.interval == `AZ_ONCE |=> !az_req_reg)
    else $error("autozero repeated in once mode");

  a_az_first_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    az.restart ##1 (az.cycle_start && az.interval != `AZ_NEVER && !az.restart) |=> az_req_reg)
    else $error("first cycle after restart missed autozero");
endmodule

//--- core/als_irq_ctrl.sv
// Status flags, interrupt pin, sleep-after-interrupt oscillator gating and autozero requests.
// Assumes an I2C byte engine on clk_i gives one-cycle read and write strobes with an address,
// and the conversion logic gives one-cycle event pulses on clk_i.
`include "als_cfg.svh"

module als_irq_ctrl
  import als_pkg::*;
(
  input  wire logic      clk_i,          // 250 MHz clock
  input  wire logic      rst_n_i,        // Synchronous reset, active low
  input  wire reg_byte_t reg_addr_i,     // Register address from the I2C engine
  input  wire reg_byte_t reg_wdata_i,    // Write data byte
  input  wire logic      reg_wr_i,       // Write strobe, one cycle
  input  wire logic      reg_rd_i,       // Read strobe, one cycle
  input  wire logic      power_on_i,     // Power-on bit from the enable register
  input  wire logic      cycle_start_i,  // A conversion cycle is about to start
  input  wire logic      cycle_done_i,   // A conversion cycle has ended
  input  wire logic      als_thresh_i,   // Threshold and persistence met
  input  wire logic      als_sat_i,      // Analog front end saturated
  output reg_byte_t      reg_rdata_o,    // Read data, valid the cycle after reg_rd_i
  output logic           osc_en_o,       // Internal oscillator enable
  output logic           power_on_rd_o,  // Power-on value software reads back
  output logic           autozero_o,     // Run autozero before this cycle
  output logic           int_out_o,      // Interrupt pin drive level
  output logic           int_oe_o        // Interrupt pin enable, high pulls the line low
);
  reg_byte_t  irq_mode_config_reg;
  reg_byte_t  autozero_schedule_reg;
  reg_byte_t  irq_enable_mask_reg;
  logic       als_flag_reg, als_flag_next;
  logic       sat_flag_reg, sat_flag_next;
  osc_state_t state_reg, state_next;
  reg_byte_t  rdata_reg;
  logic       osc_reg, power_on_rd_reg, int_oe_reg, int_out_reg, power_on_prev_reg;
  logic       status_rd, status_wr, clr_all, clr_any, irq_next, als_pend_next;

  az_if az();

  assign status_rd = reg_rd_i && reg_addr_i == `ADDR_STATUS;
  assign status_wr = reg_wr_i && reg_addr_i == `ADDR_STATUS;
  assign clr_all   = status_rd && irq_mode_config_reg[`BIT_CLEAR_ON_READ];

  // A new event in the clearing cycle survives: set wins over clear
  assign als_flag_next = als_thresh_i ||
    (als_flag_reg && !clr_all && !(status_wr && reg_wdata_i[`BIT_ALS_FLAG]));
  assign sat_flag_next = als_sat_i ||
    (sat_flag_reg && !clr_all && !(status_wr && reg_wdata_i[`BIT_SAT_FLAG]));

  assign clr_any = clr_all || (status_wr && (reg_wdata_i[`BIT_ALS_FLAG] || reg_wdata_i[`BIT_SAT_FLAG]));
  assign als_pend_next = als_flag_next && irq_enable_mask_reg[`BIT_ALS_EN];
  assign irq_next = als_pend_next || (sat_flag_next && irq_enable_mask_reg[`BIT_SAT_EN]);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_mode_config_reg   <= `RST_IRQ_MODE;
      autozero_schedule_reg <= `RST_AZ_SCHED;
      irq_enable_mask_reg   <= `RST_IRQ_EN;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_IRQ_MODE) begin
        irq_mode_config_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `ADDR_AZ_SCHED) begin
        autozero_schedule_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `ADDR_IRQ_EN) begin
        irq_enable_mask_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      als_flag_reg <= 1'b0;
      sat_flag_reg <= 1'b0;
    end else begin
      als_flag_reg <= als_flag_next;
      sat_flag_reg <= sat_flag_next;
    end
  end

  // Read data reflects the flags before any clear caused by this same read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= `RD_IDLE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ADDR_STATUS: begin
          rdata_reg <= `RD_IDLE;
          rdata_reg[`BIT_ALS_FLAG] <= als_flag_reg;
          rdata_reg[`BIT_SAT_FLAG] <= sat_flag_reg;
        end
        `ADDR_IRQ_MODE: rdata_reg <= irq_mode_config_reg;
        `ADDR_AZ_SCHED: rdata_reg <= autozero_schedule_reg;
        `ADDR_IRQ_EN:   rdata_reg <= irq_enable_mask_reg;
        default:        rdata_reg <= `RD_IDLE;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OSC_RUN: begin
        if (cycle_done_i && irq_mode_config_reg[`BIT_SLEEP_IRQ] && als_pend_next) begin
          state_next = OSC_SLEEP;
        end
      end
      OSC_SLEEP: begin
        if (clr_any && !als_pend_next) begin
          state_next = OSC_RUN;
        end
      end
      default: state_next = OSC_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= OSC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_reg         <= 1'b0;
      power_on_rd_reg <= 1'b0;
    end else begin
      osc_reg         <= power_on_i && state_next == OSC_RUN;
      power_on_rd_reg <= power_on_i;
    end
  end

  // Open-drain pin: level is fixed low, only the enable moves
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_oe_reg  <= 1'b0;
      int_out_reg <= 1'b0;
    end else begin
      int_oe_reg  <= irq_next;
      int_out_reg <= 1'b0;
    end
  end

  // Power-on rising edge restarts the autozero schedule
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_on_prev_reg <= 1'b0;
    end else begin
      power_on_prev_reg <= power_on_i;
    end
  end

  assign az.cycle_start = cycle_start_i && state_reg == OSC_RUN && power_on_i;
  assign az.restart     = power_on_i && !power_on_prev_reg;
  assign az.interval    = autozero_schedule_reg[`AZ_MSB:0];

  az_sched u_az_sched (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .az      (az.sched)
  );

  assign reg_rdata_o   = rdata_reg;
  assign osc_en_o      = osc_reg;
  assign power_on_rd_o = power_on_rd_reg;
  assign autozero_o    = az.az_req;
  assign int_out_o     = int_out_reg;
  assign int_oe_o      = int_oe_reg;

  a_read_clears_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_rd && irq_mode_config_reg[`BIT_CLEAR_ON_READ] && !als_thresh_i && !als_sat_i
    |=> !als_flag_reg && !sat_flag_reg)
    else $error("flags survived a clearing read");

  a_read_keeps_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    als_flag_reg && !irq_mode_config_reg[`BIT_CLEAR_ON_READ] && !reg_wr_i |=> als_flag_reg)
    else $error("flag lost without a clear");

  a_sleep_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cycle_done_i && irq_mode_config_reg[`BIT_SLEEP_IRQ] && irq_enable_mask_reg[`BIT_ALS_EN]
    && (als_thresh_i || (als_flag_reg && !reg_wr_i && !reg_rd_i)) |=> !osc_en_o)
    else $error("oscillator kept running after enabled interrupt");

  a_wake_only_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == OSC_SLEEP && !clr_any |=> state_reg == OSC_SLEEP)
    else $error("woke without a flag clear");

  a_osc_wakes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == OSC_SLEEP && status_wr && reg_wdata_i[`BIT_ALS_FLAG] && !als_thresh_i && power_on_i
    |=> osc_en_o)
    else $error("oscillator stayed off after the flags were cleared");

  // A clearing cycle is left out: the wake that it starts is legal
  a_power_reads_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == OSC_SLEEP && power_on_i && !clr_any ##1 power_on_i |-> power_on_rd_o && !osc_en_o)
    else $error("power-on misreported while asleep");

  a_irq_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 int_oe_o == ((als_flag_reg && $past(irq_enable_mask_reg[`BIT_ALS_EN]))
                  || (sat_flag_reg && $past(irq_enable_mask_reg[`BIT_SAT_EN]))))
    else $error("interrupt pin disagrees with enabled flags");

  a_power_off_osc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !power_on_i |=> !osc_en_o)
    else $error("oscillator on with power-on cleared");

  a_w1c_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_wr && reg_wdata_i[`BIT_SAT_FLAG] && !als_sat_i |=> !sat_flag_reg)
    else $error("write one did not clear saturation flag");

  a_event_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    als_thresh_i |=> als_flag_reg)
    else $error("threshold event did not set its flag");

  a_sat_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    als_sat_i |=> sat_flag_reg)
    else $error("saturation event did not set its flag");

  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule

//--- tb/als_host_model.sv
// Host side of the register port: strobe-level reads and writes, plus the pulled-up interrupt line.
// Assumes one access per call, strobes launched just after a rising edge of clk_i.
module als_host_model
  import als_pkg::*;
(
  input  wire logic      clk_i,       // Bench clock
  input  wire reg_byte_t reg_rdata_i, // Read data from the block
  input  wire logic      int_oe_i,    // Interrupt pin enable
  input  wire logic      int_out_i,   // Interrupt pin drive level
  output reg_byte_t      reg_addr_o,  // Register address
  output reg_byte_t      reg_wdata_o, // Write byte
  output logic           reg_wr_o,    // Write strobe
  output logic           reg_rd_o,    // Read strobe
  output logic           irq_n_o      // Interrupt line level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up wins whenever the block lets go of the pin
  assign irq_n_o = int_oe_i ? int_out_i : 1'b1;
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  // Flags are cleared by writing ones to status bits
  task automatic reg_write(input reg_byte_t a, input reg_byte_t d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
    #1;
  endtask
  // Data taken once the registered answer has landed; it holds until the next read
  task automatic reg_read(input reg_byte_t a, output reg_byte_t d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    #1;
    d = reg_rdata_i;
  endtask
endmodule

//--- tb/als_irq_sleep_autozero_cfg_tb_top.sv
// Self-checking bench of the light-sensor control block: registers, interrupt, sleep, autozero.
// Assumes the host model drives the register port and this module drives the conversion events.
`include "als_cfg.svh"

module als_irq_sleep_autozero_cfg_tb_top
  import als_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic      clk_i = 1'b0;
  logic      rst_n_i = 1'b0;
  logic      power_on_i = 1'b1;
  logic      cycle_start_i = 1'b0;
  logic      cycle_done_i = 1'b0;
  logic      als_thresh_i = 1'b0;
  logic      als_sat_i = 1'b0;
  reg_byte_t reg_addr, reg_wdata, reg_rdata, d;
  logic      reg_wr, reg_rd, osc_en, po_rd, az, int_out, int_oe, irq_n;
  int        errors = 0;
  int        n_checks = 0;
  reg_byte_t ivs [3] = '{8'h02, 8'h00, 8'h7f};
  always #2 clk_i = ~clk_i;
  als_irq_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .power_on_i(power_on_i), .cycle_start_i(cycle_start_i),
    .cycle_done_i(cycle_done_i), .als_thresh_i(als_thresh_i), .als_sat_i(als_sat_i),
    .reg_rdata_o(reg_rdata), .osc_en_o(osc_en), .power_on_rd_o(po_rd), .autozero_o(az),
    .int_out_o(int_out), .int_oe_o(int_oe));
  als_host_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .int_oe_i(int_oe), .int_out_i(int_out),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .irq_n_o(irq_n));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input reg_byte_t got, input reg_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle event pulse {start, done, threshold, saturation}; returns just after the taking edge
  task automatic ev(input logic [3:0] m);
    @(posedge clk_i);
    {cycle_start_i, cycle_done_i, als_thresh_i, als_sat_i} <= m;
    @(posedge clk_i);
    {cycle_start_i, cycle_done_i, als_thresh_i, als_sat_i} <= 4'h0;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rdchk(input reg_byte_t a, input reg_byte_t exp);
    host.reg_read(a, d);
    chk(d, exp);
  endtask
  initial begin
    #20000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(2);
    rdchk(`ADDR_IRQ_MODE, `RST_IRQ_MODE);
    rdchk(`ADDR_AZ_SCHED, `RST_AZ_SCHED);
    rdchk(`ADDR_IRQ_EN, `RST_IRQ_EN);
    rdchk(8'h42, `RD_IDLE);
    rdchk(`ADDR_STATUS, 8'h00);
    chk({7'h0, osc_en}, 8'h01);
    $display("test reset_values done");
    host.reg_write(`ADDR_IRQ_EN, 8'h90);
    ev(4'b0010);
    chk({7'h0, irq_n}, 8'h00);
    rdchk(`ADDR_STATUS, 8'h10);
    rdchk(`ADDR_STATUS, 8'h10);
    host.reg_write(`ADDR_STATUS, 8'h10);
    chk({7'h0, irq_n}, 8'h01);
    ev(4'b0001);
    chk({7'h0, irq_n}, 8'h00);
    rdchk(`ADDR_STATUS, 8'h80);
    host.reg_write(`ADDR_IRQ_EN, 8'h10);
    // A new mask reaches the pin one cycle after the write lands
    tick(1);
    chk({7'h0, irq_n}, 8'h01);
    rdchk(`ADDR_IRQ_EN, 8'h10);
    host.reg_write(`ADDR_STATUS, 8'h80);
    $display("test interrupts done");
    host.reg_write(`ADDR_IRQ_MODE, 8'hcc);
    ev(4'b0010);
    rdchk(`ADDR_STATUS, 8'h10);
    rdchk(`ADDR_STATUS, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    host.reg_write(`ADDR_IRQ_MODE, `RST_IRQ_MODE);
    $display("test clear_on_read done");
    ev(4'b0010);
    ev(4'b0100);
    chk({7'h0, osc_en}, 8'h01);
    host.reg_write(`ADDR_IRQ_MODE, 8'h5c);
    ev(4'b0100);
    chk({7'h0, osc_en}, 8'h00);
    chk({7'h0, po_rd}, 8'h01);
    ev(4'b1000);
    chk({7'h0, az}, 8'h00);
    host.reg_write(`ADDR_STATUS, 8'h80);
    chk({7'h0, osc_en}, 8'h00);
    host.reg_write(`ADDR_STATUS, 8'h10);
    chk({7'h0, osc_en}, 8'h01);
    host.reg_write(`ADDR_IRQ_MODE, `RST_IRQ_MODE);
    $display("test sleep_wake done");
    foreach (ivs[i]) begin
      host.reg_write(`ADDR_AZ_SCHED, ivs[i]);
      @(posedge clk_i);
      power_on_i <= 1'b0;
      tick(2);
      chk({7'h0, osc_en}, 8'h00);
      chk({7'h0, po_rd}, 8'h00);
      ev(4'b1000);
      chk({7'h0, az}, 8'h00);
      @(posedge clk_i);
      power_on_i <= 1'b1;
      // First start follows the power-on edge directly, so the restart is exercised back to back
      for (int k = 0; k < 5; k++) begin
        ev(4'b1000);
        chk({7'h0, az}, {7'h0, ivs[i] == 8'h00 ? 1'b0 : ivs[i] == 8'h7f ? k == 0 : k % ivs[i] == 0});
      end
    end
    $display("test autozero done");
    print_verdict();
  end
endmodule
